//--- hdl/hbgc_top.sv
// h-bridge gate control logic with axi4-lite configuration registers
//
// What this block does
// - sleep low: inputs ignored, bridge off
// - pwm mode, inputs 00: all gates off
// - pwm mode, 01: low one, high two
// - pwm mode, 10: high one, low two
// - pwm mode, 11: both lows on, brake
// - mode strap latched only at wake
// - strap low phen, high indep, hiz pwm
// - digital regulator, latch, then analog regulator
// - fault output low while fault present
// - chop threshold hit: brake for off-time
// - ignore sense comparator during blanking period
// - amplifier gain selectable among four settings
// - no chopping in independent mode
// - sense over limit flags overcurrent fault
// - hold enable: amplifier hiz during brake
// - peak current for drive period, then hold
// - strong pulldown low gate while high gate wanted
// - break-before-make per half-bridge
// - peak strength selectable, sink twice source
// - phen: enable low brakes, else phase direction
// - indep: each input picks its half side
`timescale 1ns/10ps
module hbgc_top #(
   parameter int OFF_COUNT   = hbgc_pkg::OFF_CYC,
   parameter int BLANK_COUNT = hbgc_pkg::BLANK_CYC,
   parameter int DRIVE_COUNT = hbgc_pkg::DRIVE_CYC,
   parameter int DEAD_COUNT  = hbgc_pkg::DEAD_CYC,
   parameter int PUP_COUNT   = hbgc_pkg::PUP_CYC
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        sleep_bar_input,
   input  wire logic        bridge_input_one_phase,
   input  wire logic        bridge_input_two_enable,
   input  wire logic        mode_strap_level,
   input  wire logic        mode_strap_hiz,
   input  wire logic        chop_compare,
   input  wire logic        sense_over_limit,
   input  wire logic        ext_fault,
   output logic             high_gate_one,
   output logic             low_gate_one,
   output logic             high_gate_two,
   output logic             low_gate_two,
   output logic [3:0]       gate_peak_one,
   output logic [3:0]       gate_peak_two,
   output logic [3:0]       gate_strength_select,
   output logic [4:0]       sink_strength,
   output logic             strong_pulldown_one,
   output logic             strong_pulldown_two,
   output logic             digital_regulator,
   output logic             analog_regulator,
   output logic             amp_out_enable,
   output logic [1:0]       amplifier_gain,
   output logic             fault_bar_output_o,
   output logic             fault_bar_output_oe,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   typedef enum {PW_OFF, PW_DIG, PW_LATCH, PW_ON} hbgc_pwr_t;
   typedef enum {CH_IDLE, CH_BLANK, CH_SENSE, CH_OFF} hbgc_chop_t;

   hbgc_pwr_t           pwr_ff;
   hbgc_chop_t          chop_ff;
   hbgc_pkg::hbgc_mode_t mode_ff;
   logic [15:0]         pup_cnt_ff;
   logic [15:0]         chop_cnt_ff;
   logic                awake;
   logic [3:0]          want;
   logic [3:0]          gate_ff;
   logic [3:0]          dead_ff;
   logic                drive_fwd_rev;
   logic                brake;
   logic                fault_ff;
   logic                shen_ff;
   logic [1:0]          gain_ff;
   logic [3:0]          stren_ff;
   logic                aw_ff;
   logic                w_ff;
   logic [7:0]          awaddr_ff;
   logic [31:0]         wdata_ff;
   logic [3:0]          wstrb_ff;
   logic                clr_fault;

   function automatic hbgc_pkg::hbgc_mode_t strap_code(input logic lvl,
                                                     input logic hiz);
      if (hiz)
         strap_code = hbgc_pkg::HBGC_MODE_PWM;
      else if (lvl)
         strap_code = hbgc_pkg::HBGC_MODE_INDEP;
      else
         strap_code = hbgc_pkg::HBGC_MODE_PHEN;
   endfunction

   // sleep drops wake at once, so no input reaches a gate while asleep
   assign awake = (pwr_ff == PW_ON) && sleep_bar_input;

   always_ff @(posedge aclk)
   begin
      if (!aresetn || !sleep_bar_input)
      begin
         pwr_ff     <= PW_OFF;
         pup_cnt_ff <= 16'h0000;
      end
      else
      begin
         case (pwr_ff)
            PW_OFF:
               pwr_ff <= PW_DIG;
            PW_DIG:
            begin
               pup_cnt_ff <= pup_cnt_ff + 16'h0001;
               if (pup_cnt_ff >= 16'(PUP_COUNT - 1))
                  pwr_ff <= PW_LATCH;
            end
            PW_LATCH:
               pwr_ff <= PW_ON;
            PW_ON:
               pwr_ff <= PW_ON;
            default:
               pwr_ff <= PW_OFF;
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         mode_ff <= hbgc_pkg::HBGC_MODE_PWM;
      else if (pwr_ff == PW_LATCH)
         mode_ff <= strap_code(mode_strap_level, mode_strap_hiz);
   end

   assign digital_regulator = (pwr_ff != PW_OFF);
   assign analog_regulator = awake;

   // input decode, bit order hl hl
   always_comb
   begin
      want = 4'h0;
      case (mode_ff)
         hbgc_pkg::HBGC_MODE_PWM:
            case ({bridge_input_one_phase, bridge_input_two_enable})
               2'h1: want = 4'h6;
               2'h2: want = 4'h9;
               2'h3: want = 4'h5;
               default: want = 4'h0;
            endcase
         hbgc_pkg::HBGC_MODE_PHEN:
            if (!bridge_input_two_enable)
               want = 4'h5;
            else if (bridge_input_one_phase)
               want = 4'h9;
            else
               want = 4'h6;
         hbgc_pkg::HBGC_MODE_INDEP:
            want = {bridge_input_one_phase, !bridge_input_one_phase,
                    bridge_input_two_enable, !bridge_input_two_enable};
         default:
            want = 4'h0;
      endcase
      if (chop_ff == CH_OFF)
         want = 4'h5;
      if (!awake)
         want = 4'h0;
   end

   assign drive_fwd_rev = (want == 4'h9) || (want == 4'h6);

   always_ff @(posedge aclk)
   begin
      if (!aresetn || !awake || mode_ff == hbgc_pkg::HBGC_MODE_INDEP)
      begin
         chop_ff     <= CH_IDLE;
         chop_cnt_ff <= 16'h0000;
      end
      else
      begin
         case (chop_ff)
            CH_IDLE:
               if (drive_fwd_rev)
               begin
                  chop_ff     <= CH_BLANK;
                  chop_cnt_ff <= 16'h0000;
               end
            CH_BLANK:
               if (!drive_fwd_rev)
                  chop_ff <= CH_IDLE;
               else if (chop_cnt_ff >= 16'(BLANK_COUNT - 1))
                  chop_ff <= CH_SENSE;
               else
                  chop_cnt_ff <= chop_cnt_ff + 16'h0001;
            CH_SENSE:
               if (!drive_fwd_rev)
                  chop_ff <= CH_IDLE;
               else if (chop_compare)
               begin
                  chop_ff     <= CH_OFF;
                  chop_cnt_ff <= 16'h0000;
               end
            CH_OFF:
               if (chop_cnt_ff >= 16'(OFF_COUNT - 1))
                  chop_ff <= CH_IDLE;
               else
                  chop_cnt_ff <= chop_cnt_ff + 16'h0001;
            default:
               chop_ff <= CH_IDLE;
         endcase
      end
   end

   // off is immediate, on waits dead time after partner off
   // peak drive for a fixed count after each gate change
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : gate_gen
         logic [7:0] dcnt_ff;
         logic [7:0] pcnt_ff;
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               gate_ff[g] <= 1'b0;
               dcnt_ff    <= 8'h00;
            end
            else if (!want[g])
            begin
               gate_ff[g] <= 1'b0;
               dcnt_ff    <= 8'h00;
            end
            else if (gate_ff[g ^ 1] || want[g ^ 1])
               dcnt_ff <= 8'h00;
            else if (dcnt_ff >= 8'(DEAD_COUNT))
               gate_ff[g] <= 1'b1;
            else
               dcnt_ff <= dcnt_ff + 8'h01;
         end
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
               pcnt_ff <= 8'h00;
            else if (gate_ff[g] != ((dcnt_ff >= 8'(DEAD_COUNT)) &&
                                    want[g] && !gate_ff[g ^ 1] &&
                                    !want[g ^ 1]))
               pcnt_ff <= 8'(DRIVE_COUNT);
            else if (pcnt_ff != 8'h00)
               pcnt_ff <= pcnt_ff - 8'h01;
         end
         assign dead_ff[g] = (pcnt_ff != 8'h00);
      end
   endgenerate

   assign high_gate_one = gate_ff[3];
   assign low_gate_one  = gate_ff[2];
   assign high_gate_two = gate_ff[1];
   assign low_gate_two  = gate_ff[0];

   // peak strength while driving, else hold current code 0
   assign gate_peak_one = (dead_ff[3] | dead_ff[2]) ? stren_ff : 4'h0;
   assign gate_peak_two = (dead_ff[1] | dead_ff[0]) ? stren_ff : 4'h0;
   assign gate_strength_select = stren_ff;
   assign sink_strength = {stren_ff, 1'b0};

   // strong pulldown while the high gate is wanted and its low gate is off
   assign strong_pulldown_one = want[3] && !low_gate_one;
   assign strong_pulldown_two = want[1] && !low_gate_two;

   assign brake = awake && (want == 4'h5);
   // amplifier released while braking with hold enabled
   assign amp_out_enable = awake && !(shen_ff && brake);
   assign amplifier_gain = gain_ff;

   // sticky overcurrent; set wins over clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         fault_ff <= 1'b0;
      else if (awake && sense_over_limit)
         fault_ff <= 1'b1;
      else if (clr_fault)
         fault_ff <= 1'b0;
   end

   // open drain, enable low drives the pin low
   assign fault_bar_output_o  = 1'b0;
   assign fault_bar_output_oe = !(fault_ff || ext_fault);

   // axi4-lite write: address and data accepted in either order
   assign s_axi_awready = !aw_ff && !s_axi_bvalid;
   assign s_axi_wready  = !w_ff && !s_axi_bvalid;
   assign clr_fault = aw_ff && w_ff && !s_axi_bvalid &&
                      awaddr_ff == hbgc_pkg::CTRL_OFS &&
                      wstrb_ff[0] && wdata_ff[hbgc_pkg::CLRF_BIT];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_ff        <= 1'b0;
         w_ff         <= 1'b0;
         awaddr_ff    <= 8'h00;
         wdata_ff     <= 32'h00000000;
         wstrb_ff     <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= hbgc_pkg::RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_ff     <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_ff     <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (aw_ff && w_ff && !s_axi_bvalid)
         begin
            s_axi_bvalid <= 1'b1;
            aw_ff        <= 1'b0;
            w_ff         <= 1'b0;
            s_axi_bresp  <= (awaddr_ff[7:2] == hbgc_pkg::CTRL_OFS[7:2] ||
                             awaddr_ff[7:2] == hbgc_pkg::STATUS_OFS[7:2])
                            ? hbgc_pkg::RESP_OKAY : hbgc_pkg::RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // control register: hold enable, gain, strength
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         shen_ff  <= 1'b0;
         gain_ff  <= hbgc_pkg::GAIN_RST;
         stren_ff <= hbgc_pkg::STREN_RST;
      end
      else if (aw_ff && w_ff && !s_axi_bvalid &&
               awaddr_ff[7:2] == hbgc_pkg::CTRL_OFS[7:2] && wstrb_ff[0])
      begin
         shen_ff  <= wdata_ff[hbgc_pkg::SHEN_BIT];
         gain_ff  <= wdata_ff[hbgc_pkg::GAIN_LSB +: 2];
         stren_ff <= wdata_ff[hbgc_pkg::STREN_LSB +: 4];
      end
   end

   // read channel: one-cycle answer after address taken
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= hbgc_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= hbgc_pkg::RESP_OKAY;
         if (s_axi_araddr[7:2] == hbgc_pkg::CTRL_OFS[7:2])
            s_axi_rdata <= {25'h0000000, stren_ff, gain_ff, shen_ff};
         else if (s_axi_araddr[7:2] == hbgc_pkg::STATUS_OFS[7:2])
            s_axi_rdata <= {22'h000000, 2'(chop_ff), gate_ff,
                            mode_ff, awake, fault_ff};
         else
         begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= hbgc_pkg::RESP_SLVERR;
         end
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   sleep_gates_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !sleep_bar_input |=> gate_ff == 4'h0)
      else $error("gate on while asleep");
   // never both gates of a half on
   no_shoot_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !(gate_ff[3] && gate_ff[2]) && !(gate_ff[1] && gate_ff[0]))
      else $error("shoot-through");
   mode_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      awake && $past(awake) |-> $stable(mode_ff))
      else $error("mode changed while awake");
   reg_order_a: assert property (@(posedge aclk) disable iff (!aresetn)
      analog_regulator |-> digital_regulator && $past(digital_regulator))
      else $error("regulator order");
   fault_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
      fault_ff |-> !fault_bar_output_oe)
      else $error("fault not shown");
   indep_chop_a: assert property (@(posedge aclk) disable iff (!aresetn)
      mode_ff == hbgc_pkg::HBGC_MODE_INDEP |=> chop_ff == CH_IDLE)
      else $error("chop in independent mode");
   blank_first_a: assert property (@(posedge aclk) disable iff (!aresetn)
      chop_ff == CH_OFF && $past(chop_ff) != CH_OFF |->
      $past(chop_ff) == CH_SENSE)
      else $error("chop skipped blanking");
   ocp_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
      awake && sense_over_limit |=> fault_ff)
      else $error("overcurrent missed");
   amp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      shen_ff && brake |-> !amp_out_enable)
      else $error("amplifier driven in brake");
endmodule

//--- pkg/hbgc_pkg.sv
// constants and types shared by the h-bridge gate control block
package hbgc_pkg;
   // latched interface mode code
   typedef enum logic [1:0] {
      HBGC_MODE_PHEN  = 2'h0,
      HBGC_MODE_INDEP = 2'h1,
      HBGC_MODE_PWM   = 2'h2
   } hbgc_mode_t;

   // axi4-lite register byte offsets
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;

   // control register field positions
   localparam int SHEN_BIT   = 0;
   localparam int GAIN_LSB   = 1;
   localparam int STREN_LSB  = 3;
   localparam int CLRF_BIT   = 7;

   // reset values
   localparam logic [1:0] GAIN_RST  = 2'h1;
   localparam logic [3:0] STREN_RST = 4'h3;

   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // times in ns and derived 25 MHz cycle counts
   localparam int CLK_NS        = 40;
   localparam int OFF_TIME_NS   = 25000;
   localparam int BLANK_NS      = 1800;
   localparam int DRIVE_NS      = 2000;
   localparam int DEAD_NS       = 240;
   localparam int POWERUP_NS    = 400;
   localparam int OFF_CYC   = OFF_TIME_NS / CLK_NS;
   localparam int BLANK_CYC = (BLANK_NS + CLK_NS - 1) / CLK_NS;
   localparam int DRIVE_CYC = (DRIVE_NS + CLK_NS - 1) / CLK_NS;
   localparam int DEAD_CYC  = (DEAD_NS + CLK_NS - 1) / CLK_NS;
   localparam int PUP_CYC   = (POWERUP_NS + CLK_NS - 1) / CLK_NS;
endpackage

//--- verif/hbgc_bridge_model.sv
// behavioural model of the external fet bridge and its winding sense
`timescale 1ns/10ps
module hbgc_bridge_model (
   input  wire logic        aclk,
   input  wire logic        high_gate_one,
   input  wire logic        low_gate_one,
   input  wire logic        high_gate_two,
   input  wire logic        low_gate_two,
   input  wire logic [15:0] chop_level,
   output logic             chop_compare,
   output logic [15:0]      shoot_cnt
);
   logic [15:0] cur_ff = 16'h0000;
   logic        drive;
   initial chop_compare = 1'b0;
   initial shoot_cnt = 16'h0000;
   assign drive = (high_gate_one & low_gate_two) |
                  (high_gate_two & low_gate_one);
   // winding current rises only while driving
   // a stalled winding never decays, so the comparator stays high once
   // tripped and only blanking keeps a resumed drive from chopping at once
   always @(posedge aclk)
   begin
      if (drive === 1'b1)
         cur_ff <= cur_ff + 16'h0001;
      chop_compare <= (cur_ff >= chop_level);
   end
   // both fets of one half on is shoot-through
   always @(posedge aclk)
   begin
      if ((high_gate_one & low_gate_one) | (high_gate_two & low_gate_two))
         shoot_cnt <= shoot_cnt + 16'h0001;
   end
endmodule

//--- verif/hbgc_top_tb.sv
// self-checking bench for the h-bridge gate control block
`timescale 1ns/10ps
module hbgc_top_tb;
   localparam int OFF_P = 8;
   logic        aclk = 1'b0, aresetn = 1'b0, sleep_bar_input = 1'b0;
   logic        bridge_input_one_phase = 1'b0, bridge_input_two_enable = 1'b0;
   logic        mode_strap_level = 1'b0, mode_strap_hiz = 1'b1;
   logic        sense_over_limit = 1'b0, ext_fault = 1'b0, chop_compare;
   logic        high_gate_one, low_gate_one, high_gate_two, low_gate_two;
   logic [3:0]  gate_peak_one, gate_peak_two, gate_strength_select, gv;
   logic [4:0]  sink_strength;
   logic        strong_pulldown_one, strong_pulldown_two, amp_out_enable;
   logic        digital_regulator, analog_regulator, fault_pin;
   logic [1:0]  amplifier_gain, s_axi_bresp, s_axi_rresp;
   logic        fault_bar_output_o, fault_bar_output_oe;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid;
   logic [15:0] chop_lvl = 16'hFFFF, shoot;
   int          error_cnt = 0, checked = 0, cycles = 0;
   assign gv = {high_gate_one, low_gate_one, high_gate_two, low_gate_two};
   // open-drain fault line with its pull-up
   assign fault_pin = (fault_bar_output_oe === 1'b0) ? fault_bar_output_o
                                                     : 1'b1;
   always #20 aclk = ~aclk;
   hbgc_top #(.OFF_COUNT(OFF_P), .BLANK_COUNT(4), .DRIVE_COUNT(4),
      .DEAD_COUNT(2), .PUP_COUNT(2)) dut_u (.aclk, .aresetn,
      .sleep_bar_input, .bridge_input_one_phase, .bridge_input_two_enable,
      .mode_strap_level, .mode_strap_hiz, .chop_compare, .sense_over_limit,
      .ext_fault, .high_gate_one, .low_gate_one, .high_gate_two,
      .low_gate_two, .gate_peak_one, .gate_peak_two, .gate_strength_select,
      .sink_strength, .strong_pulldown_one, .strong_pulldown_two,
      .digital_regulator, .analog_regulator, .amp_out_enable,
      .amplifier_gain, .fault_bar_output_o, .fault_bar_output_oe,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   hbgc_bridge_model bridge_u (.aclk, .high_gate_one, .low_gate_one,
      .high_gate_two, .low_gate_two, .chop_level(chop_lvl), .chop_compare,
      .shoot_cnt(shoot));
   task automatic finish_test;
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge aclk);
         aw_ok = aw_ok || (s_axi_awvalid && s_axi_awready === 1'b1);
         w_ok = w_ok || (s_axi_wvalid && s_axi_wready === 1'b1);
         if (aw_ok) s_axi_awvalid <= 1'b0;
         if (w_ok) s_axi_wvalid <= 1'b0;
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk(32'(s_axi_bresp), 32'(hbgc_pkg::RESP_OKAY));
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   function automatic logic [31:0] cw(input logic sh, input logic [1:0] g,
                                      input logic [3:0] s);
      return (32'(sh) << hbgc_pkg::SHEN_BIT) | (32'(g) << hbgc_pkg::GAIN_LSB)
         | (32'(s) << hbgc_pkg::STREN_LSB);
   endfunction
   // gate table {high one, low one, high two, low two} per mode and inputs
   function automatic logic [3:0] exp_g(input hbgc_pkg::hbgc_mode_t m,
                                        input logic a, input logic b);
      case (m)
         hbgc_pkg::HBGC_MODE_PHEN: return !b ? 4'h5 : (a ? 4'h9 : 4'h6);
         hbgc_pkg::HBGC_MODE_INDEP: return {a, !a, b, !b};
         default: return a ? (b ? 4'h5 : 4'h9) : (b ? 4'h6 : 4'h0);
      endcase
   endfunction
   task automatic drive_in(input logic a, input logic b, input int n);
      bridge_input_one_phase <= a;
      bridge_input_two_enable <= b;
      cyc(n);
   endtask
   task automatic wake(input logic lv, input logic hz);
      int n;
      sleep_bar_input <= 1'b0;
      drive_in(1'($urandom), 1'($urandom), 6);
      chk(32'({gv, digital_regulator, analog_regulator}), 32'h0);
      mode_strap_level <= lv;
      mode_strap_hiz <= hz;
      sleep_bar_input <= 1'b1;
      n = 0;
      while (digital_regulator !== 1'b1 && n < 20)
      begin
         cyc(1);
         n++;
      end
      chk(32'({digital_regulator, analog_regulator}), 32'h2);
      while (analog_regulator !== 1'b1 && n < 40)
      begin
         cyc(1);
         n++;
      end
      chk(32'(analog_regulator), 32'h1);
      // a strap change after the latch instant must be ignored
      mode_strap_level <= !lv;
      mode_strap_hiz <= !hz;
      cyc(10);
   endtask
   task automatic table_run(input hbgc_pkg::hbgc_mode_t m);
      logic [31:0] d;
      logic [1:0]  r;
      for (int i = 0; i < 4; i++)
      begin
         drive_in(i[1], i[0], 16);
         chk(32'(gv), 32'(exp_g(m, i[1], i[0])));
      end
      axi_rd(hbgc_pkg::STATUS_OFS, d, r);
      chk(32'(r), 32'(hbgc_pkg::RESP_OKAY));
      chk(32'(d[3:2]), 32'(m));
   endtask
   // lengths of complete runs of one gate state over a fixed window
   task automatic runs(input logic [3:0] s, output int cnt, output int mn);
      int len;
      logic arm;
      cnt = 0;
      mn = 999;
      len = 0;
      arm = 1'b0;
      repeat (100)
      begin
         cyc(1);
         if (gv === s) len++;
         else
         begin
            if (len > 0 && arm) cnt++;
            if (len > 0 && arm && len < mn) mn = len;
            arm = 1'b1;
            len = 0;
         end
      end
   endtask
   task automatic watch(input logic a, input logic b, output logic [1:0] sn);
      sn = 2'b00;
      bridge_input_one_phase <= a;
      bridge_input_two_enable <= b;
      repeat (16)
      begin
         cyc(1);
         sn[0] = sn[0] | (strong_pulldown_one === 1'b1)
            | (strong_pulldown_two === 1'b1);
         sn[1] = sn[1] | (gate_peak_one === gate_strength_select)
            | (gate_peak_two === gate_strength_select);
      end
      chk(32'({gate_peak_one, gate_peak_two}), 32'h0);
   endtask
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 8000)
      begin
         error_cnt++;
         finish_test;
      end
   end
   initial
   begin
      logic [31:0] d;
      logic [1:0]  r, sn;
      logic [3:0]  s;
      logic [1:0]  g;
      int          cnt, mn;
      void'($urandom(33500));
      cyc(3);
      aresetn <= 1'b1;
      axi_rd(hbgc_pkg::CTRL_OFS, d, r);
      chk(d, cw(1'b0, hbgc_pkg::GAIN_RST, hbgc_pkg::STREN_RST));
      axi_rd(8'h20, d, r);
      chk({d[29:0], r}, 32'(hbgc_pkg::RESP_SLVERR));
      wake(1'b0, 1'b1);
      table_run(hbgc_pkg::HBGC_MODE_PWM);
      watch(1'b1, 1'b0, sn);
      chk(32'(sn), 32'h3);
      watch(1'b0, 1'b1, sn);
      chk(32'(sn), 32'h3);
      ext_fault <= 1'b1;
      cyc(3);
      chk(32'(fault_pin), 32'h0);
      ext_fault <= 1'b0;
      cyc(3);
      chk(32'(fault_pin), 32'h1);
      sense_over_limit <= 1'b1;
      cyc(2);
      sense_over_limit <= 1'b0;
      cyc(3);
      chk(32'(fault_pin), 32'h0);
      g = 2'($urandom);
      s = 4'(1 + $urandom % 15);
      axi_wr(hbgc_pkg::CTRL_OFS,
             cw(1'b1, g, s) | (32'h1 << hbgc_pkg::CLRF_BIT));
      cyc(3);
      chk(32'(fault_pin), 32'h1);
      chk(32'({amplifier_gain, gate_strength_select}), 32'({g, s}));
      chk(32'(sink_strength), 32'(s) * 2);
      axi_rd(hbgc_pkg::CTRL_OFS, d, r);
      chk(32'(d[6:0]), cw(1'b1, g, s));
      drive_in(1'b1, 1'b1, 16);
      chk(32'(amp_out_enable), 32'h0);
      drive_in(1'b1, 1'b0, 16);
      chk(32'(amp_out_enable), 32'h1);
      chop_lvl <= 16'h0006;
      runs(4'h5, cnt, mn);
      chk(32'(cnt > 1 && mn >= OFF_P - 4 && mn <= OFF_P + 4),
          32'h1);
      runs(4'h9, cnt, mn);
      chk(32'(cnt > 1 && mn >= 1), 32'h1);
      chop_lvl <= 16'hFFFF;
      wake(1'b0, 1'b0);
      table_run(hbgc_pkg::HBGC_MODE_PHEN);
      wake(1'b1, 1'b0);
      table_run(hbgc_pkg::HBGC_MODE_INDEP);
      drive_in(1'b1, 1'b0, 4);
      chop_lvl <= 16'h0006;
      runs(4'h5, cnt, mn);
      chk(32'(cnt), 32'h0);
      chk(32'(gv), 32'h9);
      chk(32'(shoot), 32'h0);
      finish_test;
   end
endmodule
